// >>> inc/apdly_pkg.sv
// Purpose: constants for the aperture delay adjust block
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   offsets are word indices, so byte address is four times index
// Summary of operation
// - The sampling clock is inverted while the invert bit 16 is 1.
// - With calibration off, bits 15-8 set the coarse aperture delay.
// - Bits 7-0 set the fine delay, which adds to the coarse delay.
// - Without ramping a new coarse value applies within 1024 cycles.
// - With ramping the applied coarse value steps toward the target.
// - Ramp steps are one code, or four when the rate bit is 1, per 256.
// - Only coarse bits ramp, started by a coarse write with ramp on.
// - All three registers reset to zero.
// - With calibration enabled the calibrated delay is used instead.
package apdly_pkg;
  localparam logic [9:0]  IDX_DELAY     = 10'h2B5;
  localparam logic [9:0]  IDX_RAMP      = 10'h2B8;
  localparam logic [9:0]  IDX_CTRL      = 10'h2C8;
  localparam logic [11:0] ADDR_DELAY    = {IDX_DELAY, 2'h0};
  localparam logic [11:0] ADDR_RAMP     = {IDX_RAMP, 2'h0};
  localparam logic [11:0] ADDR_CTRL     = {IDX_CTRL, 2'h0};
  localparam logic [23:0] DELAY_RESET   = 24'h000000;
  localparam logic [7:0]  RAMP_RESET    = 8'h00;
  localparam int          INV_BIT       = 16;
  localparam int          COARSE_LSB    = 8;
  localparam int          FINE_LSB      = 0;
  localparam int          RAMP_EN_BIT   = 0;
  localparam int          RAMP_RATE_BIT = 1;
  localparam int          CAL_EN_BIT    = 0;
  localparam int          STEP_CYCLES   = 256;
  localparam int          APPLY_CYCLES  = 1024;
  localparam int          SETTLE_CYCLES = 16;
  localparam logic [7:0]  STEP_SLOW     = 8'h01;
  localparam logic [7:0]  STEP_FAST     = 8'h04;
  typedef enum logic [1:0] {
    APDLY_IDLE   = 2'b00,
    APDLY_SETTLE = 2'b01,
    APDLY_RAMP   = 2'b11
  } apdly_state_e;
endpackage

// >>> hdl/apdly_tick.sv
// Purpose: one-cycle enable pulse every PERIOD cycles
// Assumes: clear restarts the count
// Notes:   used for the ramp step rate
`timescale 1ns/1ps
module apdly_tick #(
  parameter int PERIOD = 256
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic clear,
  output logic      tick
);
  localparam int W = $clog2(PERIOD);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } apdly_tick_s;
  apdly_tick_s st_reg;
  apdly_tick_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (clear) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == W'(PERIOD - 1)) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule

// >>> hdl/apdly_step.sv
// Purpose: one bounded step of the applied coarse value toward target
// Assumes: combinational only
// Notes:   clamps the last step so the target is never overshot
`timescale 1ns/1ps
module apdly_step #(
  parameter int W = 8
) (
  // values
  input  wire logic [W-1:0] applied,
  input  wire logic [W-1:0] target,
  input  wire logic [W-1:0] step,
  output logic      [W-1:0] stepped
);
  logic [W-1:0] gap;

  always_comb begin
    stepped = applied;
    if (target > applied) begin
      gap = target - applied;
      stepped = (gap > step) ? applied + step : target;
    end else begin
      gap = applied - target;
      stepped = (gap > step) ? applied - step : target;
    end
  end
endmodule

// >>> hdl/apdly_top.sv
// Purpose: aperture delay adjust registers, ramp engine and delay outputs
// Assumes: APB slave, zero wait states, pclk is the sampling clock
// Notes:   calibration engine outside; its result arrives on cal_delay
`timescale 1ns/1ps
module apdly_top #(
  parameter int COARSE_W = 8,
  parameter int FINE_W   = 8
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // calibration result
  input  wire logic [16:0]         cal_delay,
  // delay outputs
  output logic                     clock_invert,
  output logic      [COARSE_W-1:0] coarse_delay,
  output logic      [FINE_W-1:0]   fine_delay,
  output logic                     ramp_busy
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [23:0]           delay;
    logic [7:0]            ramp;
    logic                  cal_en;
    logic [COARSE_W-1:0]   applied;
    logic [10:0]           wait_cnt;
    apdly_pkg::apdly_state_e state;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  clock_invert;
    logic [COARSE_W-1:0]   coarse_out;
    logic [FINE_W-1:0]     fine_out;
    logic                  busy;
  } apdly_s;

  apdly_s              st_reg;
  apdly_s              st_next;
  logic                tick;
  logic [COARSE_W-1:0] stepped;
  logic [COARSE_W-1:0] target;
  logic [COARSE_W-1:0] step;
  logic                access;
  logic                wr;

  function automatic logic hit(input logic [11:0] a);
    hit = (a == apdly_pkg::ADDR_DELAY) || (a == apdly_pkg::ADDR_RAMP)
       || (a == apdly_pkg::ADDR_CTRL);
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign access = psel && penable;
  assign wr     = access && pwrite && hit(paddr);
  assign target = st_reg.delay[apdly_pkg::COARSE_LSB +: COARSE_W];
  assign step   = st_reg.ramp[apdly_pkg::RAMP_RATE_BIT]
                ? COARSE_W'(apdly_pkg::STEP_FAST)
                : COARSE_W'(apdly_pkg::STEP_SLOW);

  apdly_tick #(
    .PERIOD (apdly_pkg::STEP_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (st_reg.state != apdly_pkg::APDLY_RAMP),
    .tick    (tick)
  );

  apdly_step #(
    .W (COARSE_W)
  ) u_step (
    .applied (st_reg.applied),
    .target  (target),
    .step    (step),
    .stepped (stepped)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic coarse_wr;
    coarse_wr = 1'b0;
    st_next = st_reg;
    st_next.pslverr = 1'b0;
    // register writes, byte lanes honoured
    if (wr) begin
      case (paddr)
        apdly_pkg::ADDR_DELAY: begin
          st_next.delay[7:0]   = merge8(st_reg.delay[7:0], pwdata[7:0],
                                        pstrb[0]);
          st_next.delay[15:8]  = merge8(st_reg.delay[15:8], pwdata[15:8],
                                        pstrb[1]);
          st_next.delay[23:16] = merge8(st_reg.delay[23:16],
                                        pwdata[23:16], pstrb[2]);
          coarse_wr = pstrb[1];
        end
        apdly_pkg::ADDR_RAMP: begin
          st_next.ramp = merge8(st_reg.ramp, pwdata[7:0], pstrb[0]);
        end
        apdly_pkg::ADDR_CTRL: begin
          if (pstrb[0]) begin
            st_next.cal_en = pwdata[apdly_pkg::CAL_EN_BIT];
          end
        end
        default: begin
          st_next.cal_en = st_reg.cal_en;
        end
      endcase
    end
    if (access && !hit(paddr)) begin
      st_next.pslverr = 1'b1;
    end
    // read mux
    if (psel && !penable && !pwrite) begin
      case (paddr)
        apdly_pkg::ADDR_DELAY: st_next.prdata = {8'h00, st_reg.delay};
        apdly_pkg::ADDR_RAMP:  st_next.prdata = {24'h000000, st_reg.ramp};
        apdly_pkg::ADDR_CTRL:  st_next.prdata = {22'h000000, st_reg.busy,
                                 st_reg.applied, st_reg.cal_en};
        default:               st_next.prdata = 32'h00000000;
      endcase
    end
    // coarse engine
    case (st_reg.state)
      apdly_pkg::APDLY_IDLE: begin
        st_next.wait_cnt = '0;
      end
      apdly_pkg::APDLY_SETTLE: begin
        // a short settle is well inside the 1024-cycle bound
        st_next.wait_cnt = st_reg.wait_cnt + 11'h001;
        if (st_reg.wait_cnt == 11'(apdly_pkg::SETTLE_CYCLES - 1)) begin
          st_next.applied = target;
          st_next.state   = apdly_pkg::APDLY_IDLE;
        end
      end
      apdly_pkg::APDLY_RAMP: begin
        if (tick) begin
          st_next.applied = stepped;
        end
        if (st_reg.applied == target) begin
          st_next.state = apdly_pkg::APDLY_IDLE;
        end
      end
      default: begin
        st_next.state = apdly_pkg::APDLY_IDLE;
      end
    endcase
    if (coarse_wr) begin
      st_next.wait_cnt = '0;
      st_next.state = st_reg.ramp[apdly_pkg::RAMP_EN_BIT]
                    ? apdly_pkg::APDLY_RAMP
                    : apdly_pkg::APDLY_SETTLE;
    end
    st_next.busy = (st_next.state != apdly_pkg::APDLY_IDLE);
    // outputs: calibration overrides manual settings
    if (st_reg.cal_en) begin
      st_next.clock_invert = cal_delay[apdly_pkg::INV_BIT];
      st_next.coarse_out   = cal_delay[apdly_pkg::COARSE_LSB +: COARSE_W];
      st_next.fine_out     = cal_delay[apdly_pkg::FINE_LSB +: FINE_W];
    end else begin
      st_next.clock_invert = st_reg.delay[apdly_pkg::INV_BIT];
      st_next.coarse_out   = st_reg.applied;
      st_next.fine_out     =
        st_reg.delay[apdly_pkg::FINE_LSB +: FINE_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= '0;
      st_reg.delay <= apdly_pkg::DELAY_RESET;
      st_reg.ramp  <= apdly_pkg::RAMP_RESET;
      st_reg.state <= apdly_pkg::APDLY_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata       = st_reg.prdata;
  assign pready       = 1'b1;
  assign pslverr      = st_reg.pslverr;
  assign clock_invert = st_reg.clock_invert;
  assign coarse_delay = st_reg.coarse_out;
  assign fine_delay   = st_reg.fine_out;
  assign ramp_busy    = st_reg.busy;
endmodule

// >>> sim/apdly_props.sv
// Purpose: port checks for the aperture delay adjust block
// Assumes: pready always high, one word per register
// Notes:   enable bits mirrored from bus writes; ramp checks skip cal
`timescale 1ns/1ps
module apdly_props #(
  parameter int COARSE_W = 8,
  parameter int FINE_W   = 8
) (
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  // calibration and outputs
  input wire logic [16:0]         cal_delay,
  input wire logic                clock_invert,
  input wire logic [COARSE_W-1:0] coarse_delay,
  input wire logic [FINE_W-1:0]   fine_delay,
  input wire logic                ramp_busy
);
  logic       acc;
  logic       cal_en;
  logic       ramp_en;
  logic       ramp_fast;
  logic [8:0] gap;
  // pending manual coarse apply, counted so the bound needs no long range
  logic        pend;
  logic [7:0]  pend_val;
  logic [10:0] pend_cnt;
  assign acc = psel && penable && pwrite;
  // gap saturates so long idle spans never wrap into a false short gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_en    <= 1'b0;
      ramp_en   <= 1'b0;
      ramp_fast <= 1'b0;
      gap       <= 9'h000;
      pend      <= 1'b0;
      pend_val  <= 8'h00;
      pend_cnt  <= 11'h000;
    end else begin
      if (acc && paddr == apdly_pkg::ADDR_CTRL) cal_en <= pwdata[0];
      if (acc && paddr == apdly_pkg::ADDR_RAMP) ramp_en <= pwdata[0];
      if (acc && paddr == apdly_pkg::ADDR_RAMP) ramp_fast <= pwdata[1];
      gap <= $changed(coarse_delay) ? 9'h000 : gap + {8'h00, ~&gap};
      if (acc && paddr == apdly_pkg::ADDR_DELAY && pstrb[1]) begin
        pend     <= !ramp_en && !cal_en;
        pend_val <= pwdata[15:8];
        pend_cnt <= 11'h000;
      end else if (pend) begin
        pend     <= !cal_en && coarse_delay != pend_val;
        pend_cnt <= pend_cnt + {10'h000, ~&pend_cnt};
      end
    end
  end
  //////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr;
    acc && paddr == apdly_pkg::ADDR_DELAY && &pstrb[2:0] && !cal_en;
  endsequence
  sequence s_step;
    ramp_en && !cal_en && $changed(coarse_delay);
  endsequence
  // register lands at the write edge, output flop one edge later
  AST_INV: assert property (s_wr |-> ##2
    clock_invert == $past(pwdata[16], 2))
    else $error("invert bit not applied");
  AST_FINE: assert property (s_wr |-> ##2
    fine_delay == $past(pwdata[7:0], 2))
    else $error("fine delay not applied");
  AST_APPLY: assert property (pend |->
    pend_cnt < 11'h400)
    else $error("coarse delay late");
  AST_SLOW: assert property (s_step ##0 !ramp_fast |->
    8'(coarse_delay - $past(coarse_delay)) inside {8'h01, 8'hFF})
    else $error("slow ramp step wrong");
  AST_FAST: assert property (s_step ##0 ramp_fast |->
    8'(coarse_delay - $past(coarse_delay)) inside {[8'h01:8'h04], [8'hFC:8'hFF]})
    else $error("fast ramp step wrong");
  AST_GAP: assert property (s_step |-> gap >= 9'd255)
    else $error("ramp steps too close");
  AST_RESET: assert property ($rose(presetn) |-> !clock_invert &&
    coarse_delay == 8'h00 && fine_delay == 8'h00 && !ramp_busy)
    else $error("outputs not cleared by reset");
  AST_CAL: assert property (cal_en |-> ##[0:40]
    {clock_invert, coarse_delay, fine_delay} == cal_delay)
    else $error("calibrated delay not used");
endmodule
bind apdly_top apdly_props #(.COARSE_W(COARSE_W), .FINE_W(FINE_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .cal_delay(cal_delay),
  .clock_invert(clock_invert), .coarse_delay(coarse_delay),
  .fine_delay(fine_delay), .ramp_busy(ramp_busy));

// >>> sim/tb_apdly_top.sv
// Purpose: directed bench for the aperture delay adjust block
// Assumes: full byte lanes unless a scenario says otherwise; outputs
//          judged at the falling edge, except the final t_regs check
// Notes:   ramp figures are tick counts from the coarse write
`timescale 1ns/1ps
module tb_apdly_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        clock_invert, ramp_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [16:0] cal_delay;
  logic [7:0]  coarse_delay, fine_delay;
  logic [3:0]  pstrb;
  int          fails, cmp_count;
  wire logic [31:0] outv = {15'h0000, clock_invert, coarse_delay, fine_delay};
  always #50 pclk = ~pclk;
  apdly_top u_apdly_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_delay(cal_delay), .clock_invert(clock_invert),
    .coarse_delay(coarse_delay), .fine_delay(fine_delay),
    .ramp_busy(ramp_busy));
  //////////////////////////////
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task t_regs;
    apb(0, apdly_pkg::ADDR_DELAY, 0); chk(rd, 32'h0);
    apb(0, apdly_pkg::ADDR_RAMP, 0); chk(rd, 32'h0);
    apb(1, 12'h004, 32'hFFFFFFFF);
    idle(1); chk({31'h0, pslverr}, 32'h1);
    apb(0, 12'h004, 0); chk(rd, 32'h0);
    chk(outv, 32'h0);
  endtask
  task t_direct;
    int n;
    n = 0;
    apb(1, apdly_pkg::ADDR_DELAY, 32'h0001053C);
    idle(2); chk({23'h0, clock_invert, fine_delay}, 32'h13C);
    while (coarse_delay !== 8'h05 && n++ < 1022) idle(1);
    chk(outv, 32'h0001053C);
    apb(0, apdly_pkg::ADDR_DELAY, 0); chk(rd, 32'h0001053C);
    // one code per write, the safe way to move a live clock
    apb(1, apdly_pkg::ADDR_DELAY, 32'h0000063C);
    idle(2); chk(outv, 32'h0000053C);
    n = 0;
    while (coarse_delay !== 8'h06 && n++ < 1022) idle(1);
    chk(outv, 32'h0000063C);
    // coarse lane masked off: no coarse change may follow
    @(posedge pclk);
    pstrb <= 4'h5;
    apb(1, apdly_pkg::ADDR_DELAY, 32'h00010A3C);
    pstrb <= 4'hF;
    idle(40); chk(outv, 32'h0001063C);
  endtask
  // start, one tick later, then the target held after the last tick
  task t_ramp(input logic rt, input logic [7:0] s, t, f, input int k);
    apb(1, apdly_pkg::ADDR_RAMP, {30'h0, rt, 1'b1});
    apb(1, apdly_pkg::ADDR_DELAY, {16'h0, t, 8'h77});
    idle(2); chk({24'h0, fine_delay}, 32'h77);
    chk({31'h0, ramp_busy}, 32'h1);
    idle(198); chk({24'h0, coarse_delay}, {24'h0, s});
    idle(100); chk({24'h0, coarse_delay}, {24'h0, f});
    idle(256 * k);
    chk({23'h0, ramp_busy, coarse_delay}, {24'h0, t});
  endtask
  task t_cal;
    apb(1, apdly_pkg::ADDR_RAMP, 0);
    cal_delay <= 17'h1A55C;
    apb(1, apdly_pkg::ADDR_CTRL, 1);
    idle(40); chk(outv, 32'h0001A55C);
    apb(1, apdly_pkg::ADDR_DELAY, 32'h00002211);
    idle(40); chk(outv, 32'h0001A55C);
    apb(1, apdly_pkg::ADDR_CTRL, 0);
    idle(40); chk(outv, 32'h00002211);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cal_delay, fails, cmp_count} = '0;
    pstrb = 4'hF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_direct;
    t_ramp(1'b0, 8'h06, 8'h09, 8'h07, 3);
    t_ramp(1'b1, 8'h09, 8'h12, 8'h0D, 3);
    t_ramp(1'b1, 8'h12, 8'h0F, 8'h0F, 1);
    t_cal;
    stop_test;
  end
  initial begin
    repeat (10000) @(posedge pclk);
    fails++;
    stop_test;
  end
endmodule
